// ### hw/ecs_pkg.sv
package ecs_pkg;

    // Reference clock period, for reading cycle counts
    localparam int unsigned REF_CLK_PERIOD_NS = 25;

    // Bus states per access without waits
    localparam logic [1:0] STATES_SHORT = 2'h2;
    localparam logic [1:0] STATES_LONG = 2'h3;

    // Width of the helper cycle counters
    localparam int unsigned CNT_W = 10;
    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 10'h001;
    localparam logic [CNT_W-1:0] CNT_MAX = 10'h3ff;

    // Data bus reset value
    localparam logic [15:0] DATA_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SYNC = 2'b01,
        ST_ACC = 2'b10
    } ecs_fsm_t;

    typedef enum logic [1:0] {
        SP_BASIC = 2'b00,
        SP_BYTE_SRAM = 2'b01,
        SP_BURST_ROM = 2'b10,
        SP_MPX = 2'b11
    } ecs_space_t;

    // External control pins, all strobes active low
    typedef struct packed {
        logic cycleStartN;
        logic addrStrobeHoldN;
        logic readStrobeN;
        logic readNotWrite;
        logic upperByteN;
    } ecs_pins_t;

    localparam ecs_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

endpackage

// ### hw/ecs_edge_detect.sv
`timescale 1ns/100ps

module ecs_edge_detect
    import ecs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Foreign clock and its rising edge
    input wire logic clkIn,
    output logic risePulse
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } ecs_edge_t;

    ecs_edge_t stReg;
    ecs_edge_t stNext;

    // Two stages before anyone looks, third one for the edge
    always_comb
    begin
        stNext.s1 = clkIn;
        stNext.s2 = stReg.s1;
        stNext.s3 = stReg.s2;
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            stReg <= '0;
        else
            stReg <= stNext;
    end

    // Edge seen one to two cycles late; all timing is relative to it
    assign risePulse = stReg.s2 & ~stReg.s3;

endmodule

// ### hw/ecs_bus_sync.sv
`timescale 1ns/100ps

// Operation
// - Controller runs on system clock; external interface follows external bus clock.
// - Peripheral cycles follow peripheral clock, external cycles the external clock.
// - At n:1 with no waits, accesses last 2n or 3n system cycles.
// - Cycle not aligned to target clock gets sync states at its start.
// - External access inserts zero to n-1 sync cycles at n:1.
// - Peripheral access inserts zero to m-1 sync cycles at m:1.
// - Cycle-start output is asserted when an external cycle begins.
// - Address strobe marks a valid address in basic, byte SRAM, burst spaces.
// - In multiplexed space the same output is an address hold.
// - Read strobe asserted after the first bus state while any external space is read.
// - Read/write output shows direction of the current external cycle.
// - In byte SRAM space read/write acts as memory write enable.
// - Upper-byte strobe marks upper-lane writes in basic, burst, multiplexed space.
// - In byte SRAM space it selects the upper lanes on reads and writes.
module ecs_bus_sync
    import ecs_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // Target clocks, sampled
    input wire logic extBusClk,
    input wire logic periphClk,
    // Request from the system bus
    input wire logic reqValid,
    input wire logic reqExternal,
    input wire logic reqWrite,
    input wire logic [1:0] reqSpace,
    input wire logic reqThreeState,
    input wire logic reqUpperByte,
    input wire logic [15:0] reqWrData,
    // Answer to the system bus
    output logic reqReady,
    output logic reqDone,
    output logic [15:0] reqRdData,
    // External control pins
    output logic cycleStartOutN,
    output logic addrStrobeHoldN,
    output logic readStrobeN,
    output logic readNotWrite,
    output logic upperByteStrobeN,
    // External data bus
    input wire logic [15:0] extDataIn,
    output logic [15:0] extDataOut,
    output logic extDataOeUpper,
    output logic extDataOeLower,
    // Peripheral side
    output logic periphSel
);

    typedef struct packed {
        ecs_fsm_t fsm;
        logic ext;
        logic write;
        ecs_space_t space;
        logic [1:0] lastIdx;
        logic [1:0] idx;
        logic upper;
        logic ready;
        logic done;
        logic periph;
        logic oeUpper;
        logic oeLower;
        ecs_pins_t pins;
        logic [15:0] wrData;
        logic [15:0] rdData;
        logic [15:0] dIn1;
        logic [15:0] dIn2;
        logic [CNT_W-1:0] syncCnt;
        logic [CNT_W-1:0] accCnt;
        logic [CNT_W-1:0] sinceExt;
        logic [CNT_W-1:0] extPeriod;
        logic [CNT_W-1:0] sincePer;
        logic [CNT_W-1:0] perPeriod;
    } ecs_state_t;

    ecs_state_t stReg;
    ecs_state_t stNext;
    logic extEdge;
    logic perEdge;
    logic tgtEdge;

    // Rising edges of both target clocks in the system domain
    ecs_edge_detect extDet (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkIn(extBusClk),
        .risePulse(extEdge)
    );

    ecs_edge_detect perDet (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clkIn(periphClk),
        .risePulse(perEdge)
    );

    // Pin levels for a given bus state; peripherals leave pins idle
    function automatic ecs_pins_t pinsFor(input logic ext, input ecs_space_t space,
        input logic write, input logic upper, input logic [1:0] idx);
        ecs_pins_t p;
        logic first;
        first = (idx == 2'h0);
        p = PINS_IDLE;
        if (ext)
        begin
            p.cycleStartN = !first;
            p.addrStrobeHoldN = (space == SP_MPX) ? !first : 1'b0;
            p.readStrobeN = write | first;
            p.readNotWrite = !write;
            if (space == SP_BYTE_SRAM)
                p.upperByteN = !upper;
            else
                p.upperByteN = !(write && upper) | first;
        end
        return p;
    endfunction

    // Edge of whichever clock the cycle in flight follows
    assign tgtEdge = stReg.ext ? extEdge : perEdge;

    // Sequencer, period measurement and data path
    always_comb
    begin
        stNext = stReg;
        stNext.done = 1'b0;
        stNext.dIn1 = extDataIn;
        stNext.dIn2 = stReg.dIn1;
        // Target periods measured for the sync bound checks
        stNext.sinceExt = extEdge ? CNT_ZERO :
            (stReg.sinceExt == CNT_MAX ? CNT_MAX : stReg.sinceExt + CNT_ONE);
        stNext.sincePer = perEdge ? CNT_ZERO :
            (stReg.sincePer == CNT_MAX ? CNT_MAX : stReg.sincePer + CNT_ONE);
        if (extEdge)
            stNext.extPeriod = stReg.sinceExt + CNT_ONE;
        if (perEdge)
            stNext.perPeriod = stReg.sincePer + CNT_ONE;
        unique case (stReg.fsm)
            ST_IDLE:
            begin
                stNext.syncCnt = CNT_ZERO;
                stNext.accCnt = CNT_ZERO;
                if (reqValid && stReg.ready)
                begin
                    stNext.ready = 1'b0;
                    stNext.ext = reqExternal;
                    stNext.write = reqWrite;
                    stNext.space = ecs_space_t'(reqSpace);
                    stNext.upper = reqUpperByte;
                    stNext.wrData = reqWrData;
                    stNext.lastIdx = (reqThreeState ? STATES_LONG : STATES_SHORT) - 2'h1;
                    stNext.idx = 2'h0;
                    // Aligned request starts at once, else wait for the edge
                    if (reqExternal ? extEdge : perEdge)
                    begin
                        stNext.fsm = ST_ACC;
                        stNext.pins = pinsFor(reqExternal, ecs_space_t'(reqSpace),
                            reqWrite, reqUpperByte, 2'h0);
                        stNext.periph = !reqExternal;
                        stNext.oeUpper = reqExternal && reqWrite && reqUpperByte;
                        stNext.oeLower = reqExternal && reqWrite;
                    end
                    else
                        stNext.fsm = ST_SYNC;
                end
            end
            ST_SYNC:
            begin
                stNext.syncCnt = stReg.syncCnt + CNT_ONE;
                if (tgtEdge)
                begin
                    stNext.fsm = ST_ACC;
                    stNext.pins = pinsFor(stReg.ext, stReg.space, stReg.write,
                        stReg.upper, 2'h0);
                    stNext.periph = !stReg.ext;
                    stNext.oeUpper = stReg.ext && stReg.write && stReg.upper;
                    stNext.oeLower = stReg.ext && stReg.write;
                end
            end
            ST_ACC:
            begin
                // Each bus state spans one target period
                stNext.accCnt = stReg.accCnt + CNT_ONE;
                if (tgtEdge)
                begin
                    if (stReg.idx == stReg.lastIdx)
                    begin
                        stNext.fsm = ST_IDLE;
                        stNext.ready = 1'b1;
                        stNext.done = 1'b1;
                        stNext.pins = PINS_IDLE;
                        stNext.periph = 1'b0;
                        stNext.oeUpper = 1'b0;
                        stNext.oeLower = 1'b0;
                        if (!stReg.write)
                            stNext.rdData = stReg.dIn2;
                    end
                    else
                    begin
                        stNext.idx = stReg.idx + 2'h1;
                        stNext.pins = pinsFor(stReg.ext, stReg.space, stReg.write,
                            stReg.upper, stReg.idx + 2'h1);
                    end
                end
            end
            default:
                stNext.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stReg <= '0;
            stReg.fsm <= ST_IDLE;
            stReg.ready <= 1'b1;
            stReg.pins <= PINS_IDLE;
            stReg.lastIdx <= STATES_SHORT - 2'h1;
            stReg.wrData <= DATA_RESET;
            stReg.rdData <= DATA_RESET;
        end
        else
            stReg <= stNext;
    end

    // Outputs straight from the state register
    assign reqReady = stReg.ready;
    assign reqDone = stReg.done;
    assign reqRdData = stReg.rdData;
    assign cycleStartOutN = stReg.pins.cycleStartN;
    assign addrStrobeHoldN = stReg.pins.addrStrobeHoldN;
    assign readStrobeN = stReg.pins.readStrobeN;
    assign readNotWrite = stReg.pins.readNotWrite;
    assign upperByteStrobeN = stReg.pins.upperByteN;
    assign extDataOut = stReg.wrData;
    assign extDataOeUpper = stReg.oeUpper;
    assign extDataOeLower = stReg.oeLower;
    assign periphSel = stReg.periph;

    // Checks
    logic inAcc;
    logic [CNT_W-1:0] expLen;
    assign inAcc = (stReg.fsm == ST_ACC);
    assign expLen = CNT_W'({stReg.lastIdx + 2'h1} * stReg.extPeriod);

    chk_sync_insert: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stReg.fsm == ST_IDLE && reqValid && stReg.ready && !(reqExternal ? extEdge : perEdge))
        |=> stReg.fsm == ST_SYNC) else $error("unaligned request skipped sync states");
    chk_sync_exit_edge: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stReg.fsm == ST_SYNC) |=> (stReg.fsm == ST_ACC) == $past(tgtEdge))
        else $error("sync state left off the target edge");
    chk_ext_sync_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stReg.fsm == ST_SYNC && stReg.ext && tgtEdge)
        |-> stReg.syncCnt + CNT_ONE < stReg.extPeriod)
        else $error("too many external sync cycles");
    chk_per_sync_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (stReg.fsm == ST_SYNC && !stReg.ext && tgtEdge)
        |-> stReg.syncCnt + CNT_ONE < stReg.perPeriod)
        else $error("too many peripheral sync cycles");
    chk_access_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (inAcc && stReg.ext && tgtEdge && stReg.idx == stReg.lastIdx && $stable(stReg.extPeriod))
        |-> stReg.accCnt + CNT_ONE == expLen) else $error("external access length wrong");
    chk_start_first: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $rose(inAcc) && stReg.ext |-> !cycleStartOutN ##1 (!cycleStartOutN) [*1])
        else $error("cycle start missing at first state");
    chk_start_only: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !cycleStartOutN |-> inAcc && stReg.ext && stReg.idx == 2'h0)
        else $error("cycle start outside first state");
    chk_addr_valid: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.ext && stReg.space != SP_MPX |-> !addrStrobeHoldN)
        else $error("address strobe not asserted");
    chk_mpx_hold: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.ext && stReg.space == SP_MPX |-> addrStrobeHoldN == (stReg.idx != 2'h0))
        else $error("address hold wrong in multiplexed space");
    chk_read_strobe: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !readStrobeN |-> inAcc && stReg.ext && !stReg.write && stReg.idx != 2'h0)
        else $error("read strobe outside external read");
    chk_direction: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.ext |-> readNotWrite == !stReg.write) else $error("direction wrong");
    chk_upper_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !upperByteStrobeN && stReg.space != SP_BYTE_SRAM |-> stReg.write && extDataOeUpper)
        else $error("upper write strobe without upper write");
    chk_upper_sram: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.ext && stReg.space == SP_BYTE_SRAM && stReg.upper |-> !upperByteStrobeN)
        else $error("upper byte select missing in byte SRAM");
    chk_periph_quiet: assert property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && !stReg.ext |-> periphSel && cycleStartOutN && readStrobeN)
        else $error("peripheral access touched external pins");

    cov_ext_sync: cover property (@(posedge ref_clk) disable iff (!rst_n)
        stReg.fsm == ST_SYNC && stReg.ext ##1 inAcc);
    cov_ext_long: cover property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.ext && stReg.idx == 2'h2);
    cov_periph_done: cover property (@(posedge ref_clk) disable iff (!rst_n)
        reqDone && !stReg.ext);
    cov_sram_write: cover property (@(posedge ref_clk) disable iff (!rst_n)
        inAcc && stReg.space == SP_BYTE_SRAM && stReg.write);

endmodule

// ### tb/ecs_ext_model.sv
`timescale 1ns/100ps

module ecs_ext_model
    import ecs_pkg::*;
#(
    parameter logic [15:0] READ_WORD = 16'ha55a
)
(
    // Clock
    input wire logic ref_clk,
    // External bus clock, free running
    output logic extBusClk,
    // Control and data from the block
    input wire logic readStrobeN,
    input wire logic readNotWrite,
    input wire logic extDataOeUpper,
    input wire logic extDataOeLower,
    input wire logic [15:0] extDataOut,
    // Data toward the block
    output logic [15:0] extDataIn,
    output logic [15:0] lastWrite
);
    // Odd offset keeps the bus clock out of phase with ref_clk
    initial
    begin
        extBusClk = 1'b0;
        #7;
        forever #100 extBusClk = ~extBusClk;
    end

    // Word only while read strobe is low, inverse otherwise so stale data never matches
    always_comb extDataIn = readStrobeN ? ~READ_WORD : READ_WORD;

    // Memory takes each enabled lane while write enable is low
    always @(posedge ref_clk)
    begin
        if (readNotWrite === 1'b0 && extDataOeLower === 1'b1)
            lastWrite[7:0] <= extDataOut[7:0];
        if (readNotWrite === 1'b0 && extDataOeUpper === 1'b1)
            lastWrite[15:8] <= extDataOut[15:8];
    end
endmodule

// ### tb/external_bus_cycle_sync_tb.sv
`timescale 1ns/100ps

module external_bus_cycle_sync_tb
    import ecs_pkg::*;
;
    localparam logic [15:0] RD_WORD = 16'hc3a5;
    logic ref_clk, rst_n, extBusClk, periphClk, reqValid, reqExternal, reqWrite;
    logic reqThreeState, reqUpperByte, reqReady, reqDone, cycleStartOutN, addrStrobeHoldN;
    logic readStrobeN, readNotWrite, upperByteStrobeN, extDataOeUpper, extDataOeLower;
    logic periphSel, prevB, prevP;
    logic [1:0] reqSpace;
    logic [15:0] reqWrData, reqRdData, extDataIn, extDataOut, lastWrite;
    int errors = 0, samples_checked = 0;
    int nCs, nAs, nRd, nWe, nUp, nOeU, nSel, lat, phase, sinceB, sinceP;

    ecs_bus_sync i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .extBusClk(extBusClk),
        .periphClk(periphClk), .reqValid(reqValid), .reqExternal(reqExternal),
        .reqWrite(reqWrite), .reqSpace(reqSpace), .reqThreeState(reqThreeState),
        .reqUpperByte(reqUpperByte), .reqWrData(reqWrData), .reqReady(reqReady),
        .reqDone(reqDone), .reqRdData(reqRdData), .cycleStartOutN(cycleStartOutN),
        .addrStrobeHoldN(addrStrobeHoldN), .readStrobeN(readStrobeN),
        .readNotWrite(readNotWrite), .upperByteStrobeN(upperByteStrobeN),
        .extDataIn(extDataIn), .extDataOut(extDataOut), .extDataOeUpper(extDataOeUpper),
        .extDataOeLower(extDataOeLower), .periphSel(periphSel));
    ecs_ext_model #(.READ_WORD(RD_WORD)) i_mem (.ref_clk(ref_clk), .extBusClk(extBusClk),
        .readStrobeN(readStrobeN), .readNotWrite(readNotWrite),
        .extDataOeUpper(extDataOeUpper), .extDataOeLower(extDataOeLower),
        .extDataOut(extDataOut), .extDataIn(extDataIn), .lastWrite(lastWrite));

    // Clocks: 40 MHz system, 100 ns peripheral (m=4) at an unrelated phase
    initial
    begin
        ref_clk = 1'b0;
        forever #(REF_CLK_PERIOD_NS / 2.0) ref_clk = ~ref_clk;
    end
    initial
    begin
        periphClk = 1'b0;
        #13;
        forever #50 periphClk = ~periphClk;
    end

    // Cycles since each target clock pin last rose
    always @(posedge ref_clk)
    begin
        prevB <= extBusClk;
        prevP <= periphClk;
        sinceB <= (extBusClk && !prevB) ? 0 : sinceB + 1;
        sinceP <= (periphClk && !prevP) ? 0 : sinceP + 1;
    end

    task automatic finish_test();
        $display("Checked %0d, errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check_cnt(input string name, input int lo, input int hi, input int got);
        samples_checked++;
        if (got < lo || got > hi)
        begin
            errors++;
            $display("Error %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask

    // One access, entered at a falling edge; counts strobe cycles until done
    task automatic do_access(input logic ext, input logic wr, input logic [1:0] sp,
        input logic three, input logic up, input logic [15:0] wd);
        int guard;
        {nCs, nAs, nRd, nWe, nUp, nOeU, nSel, phase, guard} = '0;
        {reqExternal, reqWrite, reqSpace, reqThreeState, reqUpperByte} = {ext, wr, sp, three, up};
        reqWrData = wd;
        reqValid = 1'b1;
        while (reqReady !== 1'b1 && guard < 50)
        begin
            @(negedge ref_clk);
            guard++;
        end
        @(negedge ref_clk);
        reqValid = 1'b0;
        for (lat = 1; reqDone !== 1'b1 && lat < 100; lat++)
        begin
            if (nCs + nSel == 0 && (cycleStartOutN === 1'b0 || periphSel === 1'b1))
                phase = ext ? sinceB : sinceP;
            nCs += (cycleStartOutN === 1'b0);
            nAs += (addrStrobeHoldN === 1'b0);
            nRd += (readStrobeN === 1'b0);
            nWe += (readNotWrite === 1'b0);
            nUp += (upperByteStrobeN === 1'b0);
            nOeU += (extDataOeUpper === 1'b1);
            nSel += (periphSel === 1'b1);
            @(negedge ref_clk);
        end
        if (guard >= 50 || lat >= 100)
        begin
            errors++;
            $display("Error handshake expected done seen none");
            finish_test();
        end
    endtask

    // Two-state basic write with upper lanes
    task automatic test_ext_write();
        do_access(1'b1, 1'b1, SP_BASIC, 1'b0, 1'b1, 16'h3c5a);
        check_cnt("latency", 17, 24, lat);
        check_cnt("start", 8, 8, nCs);
        check_cnt("addr", 16, 16, nAs);
        check_cnt("dir", 16, 16, nWe);
        check_cnt("upper", 8, 8, nUp);
        check_cnt("upperoe", 16, 16, nOeU);
        check_cnt("read", 0, 0, nRd);
        check_val("wdata", 16'h3c5a, lastWrite);
        check_cnt("phase", 2, 5, phase);
    endtask

    // Three-state reads in every space
    task automatic test_ext_reads();
        for (int s = 0; s < 4; s++)
        begin
            do_access(1'b1, 1'b0, s[1:0], 1'b1, 1'b1, 16'h0000);
            check_cnt("latency", 25, 32, lat);
            check_cnt("read", 16, 16, nRd);
            check_cnt("addr", s == 3 ? 8 : 24, s == 3 ? 8 : 24, nAs);
            check_cnt("upper", s == 1 ? 24 : 0, s == 1 ? 24 : 0, nUp);
            check_cnt("dir", 0, 0, nWe);
            check_val("rdata", RD_WORD, reqRdData);
        end
    endtask

    // Byte SRAM writes, with and without the upper lanes
    task automatic test_sram_write();
        do_access(1'b1, 1'b1, SP_BYTE_SRAM, 1'b1, 1'b1, 16'h9e21);
        check_cnt("we", 24, 24, nWe);
        check_cnt("upper", 24, 24, nUp);
        do_access(1'b1, 1'b1, SP_BYTE_SRAM, 1'b1, 1'b0, 16'h4417);
        check_cnt("upper", 0, 0, nUp + nOeU);
        check_val("wdata", 16'h9e17, lastWrite);
    endtask

    // Peripheral read, then a write back to back, both on periphClk with pins idle
    task automatic test_periph();
        do_access(1'b0, 1'b0, SP_BASIC, 1'b0, 1'b0, 16'h0000);
        check_cnt("latency", 9, 12, lat);
        check_cnt("sel", 8, 8, nSel);
        check_cnt("pins", 0, 0, nCs + nAs + nRd);
        check_cnt("phase", 2, 5, phase);
        // Taken in the done cycle, so the full m-1 sync states come first
        do_access(1'b0, 1'b1, SP_BASIC, 1'b0, 1'b1, 16'h5aa5);
        check_cnt("latency", 12, 12, lat);
        check_cnt("sel", 8, 8, nSel);
        check_cnt("pins", 0, 0, nCs + nAs + nWe + nUp + nOeU);
        check_val("wdata", 16'h9e17, lastWrite);
    endtask

    // Requests at every phase of the bus clock, back to back at gap zero
    task automatic test_phases();
        for (int g = 0; g < 8; g++)
        begin
            repeat (g) @(negedge ref_clk);
            do_access(1'b1, 1'b0, SP_BURST_ROM, 1'b0, 1'b0, 16'h0000);
            check_cnt("latency", 17, 24, lat);
            check_cnt("phase", 2, 5, phase);
        end
    endtask

    initial
    begin
        {rst_n, reqValid, reqExternal, reqWrite, reqThreeState, reqUpperByte} = '0;
        reqSpace = SP_BASIC;
        reqWrData = 16'h0000;
        repeat (5) @(negedge ref_clk);
        rst_n = 1'b1;
        check_val("ready", 16'h0001, {15'h0000, reqReady});
        check_val("dir", 16'h0001, {15'h0000, readNotWrite});
        check_val("idle", 16'h0001, {15'h0000, cycleStartOutN});
        // Edge detectors need a few target periods of history
        repeat (40) @(negedge ref_clk);
        test_ext_write();
        test_ext_reads();
        test_sram_write();
        test_periph();
        test_phases();
        finish_test();
    end
endmodule
